// ---- verilog/ldw_top.sv ----
// Purpose: Write-only serial slave and register bank of a one-channel
//          LED current driver.
// Assumes: SCL and SDA are oversampled by the 100 MHz clock.
// Notes:   SDA is open drain: sda_oe_o high pulls the line low.
//          Timing bytes are stored whole; their fields are not decoded.
// How it works
// RQ1: Answer only the seven-bit address 1101000 in the upper address bits.
// RQ2: Master always sends a zero read/write bit; only writes exist.
// RQ3: SDA is sampled while SCL is high; ours changes only when low.
// RQ4: Master leaves SDA released high while the bus is idle.
// RQ5: SDA falling with SCL high is start; then compare the address.
// RQ6: Master sends the address byte MSB first, stable while SCL high.
// RQ7: On matching address, hold SDA low through the whole ninth clock.
// RQ8: Without acknowledge the master stops and abandons the transfer.
// RQ9: Register address byte follows, MSB first, and is acknowledged.
// RQ10: Data bytes follow MSB first, each acknowledged.
// RQ11: SDA rising with SCL high is stop; return to idle.
// RQ12: Register pointer steps by one during each data acknowledge.
// RQ13: Power-down bit 0 shuts down (reset one); bit 5 enables channel.
// RQ14: Ramp bit 5 enables ramping; bit 4 picks second or fourth hold.
// RQ15: Mode bit 5 picks direct duty (zero) or one-shot breathing.
// RQ16: Current field 4:2 maps 42, 10, 5, 30 mA, 1xx to 17.5 mA.
// RQ17: Direct mode uses all eight duty bits, value over 256.
// RQ18: One-shot mode uses duty bits 7:1 and ignores bit 0.
// RQ19: Duty writes are staged; writing zero to 07h applies them.
// RQ20: Timing writes are staged; writing zero to 1Ch applies all three.
// RQ21: Writing zero to 2Fh restores every register default, as reset.
// RQ22: Output on/off bit 0 turns output on when one, reset one.
// RQ23: Address with read bit set gets no acknowledge; idle until start.
// RQ24: Repeated start aborts the byte and restarts address comparison.
`timescale 1ns/1ns
`default_nettype none
module ldw_top
	import ldw_pkg::*;
(
	input  wire logic clock_i,   // System clock, 100 MHz.
	input  wire logic rst_n_i,   // Asynchronous reset, active low.
	input  wire logic scl_i,     // Serial clock pin level.
	input  wire logic sda_i,     // Serial data pin level.
	output logic      sda_o,     // Serial data drive value, always low.
	output logic      sda_oe_o,  // High while pulling SDA low.
	output ldw_ctrl_t ctrl_o,    // Applied control settings.
	output ldw_time_t time_o     // Applied timing settings.
);

	typedef enum logic [2:0] {
		LDW_IDLE,
		LDW_ADDR,
		LDW_REG,
		LDW_DATA,
		LDW_ACK,
		LDW_SKIP
	} ldw_state_t;

	logic       scl_s;
	logic       sda_s;
	logic       scl_prev_q;
	logic       sda_prev_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	ldw_state_t state_q;
	ldw_state_t after_ack_q;
	logic [7:0] shift_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] ptr_q;
	logic       ack_drive_q;
	ldw_wr_t    wr_q;

	logic [7:0] pdown_q;
	logic [7:0] ramp_q;
	logic [7:0] mode_q;
	logic [7:0] curr_q;
	logic [7:0] duty_stage_q;
	logic [7:0] duty_act_q;
	logic [7:0] tstart_stage_q;
	logic [7:0] trise_stage_q;
	logic [7:0] tfall_stage_q;
	ldw_time_t  time_q;
	logic [7:0] onoff_q;

	// Decodes a strobe write at a given offset with the key value.
	function automatic logic strobe_hit(input ldw_wr_t w,
	                                    input logic [7:0] ofs);
		strobe_hit = w.valid && (w.addr == ofs) && (w.data == LDW_STROBE_KEY);
	endfunction

	// Maps the three-bit current field onto the five levels.
	function automatic ldw_imax_t imax_map(input logic [2:0] cs);
		if (cs[2]) begin
			imax_map = LDW_I_17MA5; // RQ16
		end else begin
			imax_map = ldw_imax_t'(cs); // RQ16
		end
	endfunction

	ldw_pin_sync #(.RST_VAL(1'b1)) u_scl_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (scl_i),
		.level_o (scl_s)
	);

	ldw_pin_sync #(.RST_VAL(1'b1)) u_sda_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (sda_i),
		.level_o (sda_s)
	);

	// Previous filtered levels for edge detection.
	// They reset to the idle high level so no false edge follows reset.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// Bus events; SDA edges with SCL high are start and stop.
	assign scl_rise  = scl_s && !scl_prev_q;
	assign scl_fall  = !scl_s && scl_prev_q;
	assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s; // RQ5
	assign stop_det  = scl_s && scl_prev_q && !sda_prev_q && sda_s; // RQ11

	// Byte engine: shifts bits on SCL rise, steps states on SCL fall.
	// Both pins pass the same filter delay, so their order is kept, and
	// the acknowledge is launched from a filtered fall: it can only move
	// while the pin clock is already low.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q     <= LDW_IDLE;
			after_ack_q <= LDW_IDLE;
			shift_q     <= 8'h00;
			bit_cnt_q   <= 4'h0;
			ptr_q       <= 8'h00;
			ack_drive_q <= 1'b0;
			wr_q        <= '0;
		end else begin
			wr_q.valid <= 1'b0;
			if (start_det) begin
				state_q     <= LDW_ADDR; // RQ5 RQ24
				bit_cnt_q   <= 4'h0;
				ack_drive_q <= 1'b0;
			end else if (stop_det) begin
				state_q     <= LDW_IDLE; // RQ11
				ack_drive_q <= 1'b0;
			end else begin
				case (state_q)
				LDW_ADDR, LDW_REG, LDW_DATA: begin
					if (scl_rise && bit_cnt_q < 4'h8) begin
						shift_q   <= {shift_q[6:0], sda_s}; // RQ3
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == 4'h8) begin
						bit_cnt_q <= 4'h0;
						ack_drive_q <= 1'b1;
						state_q <= LDW_ACK;
						if (state_q == LDW_ADDR) begin
							if (shift_q[7:1] == LDW_DEV_ADDR && !shift_q[0]) begin
								after_ack_q <= LDW_REG; // RQ1 RQ7
							end else begin
								ack_drive_q <= 1'b0; // RQ23
								state_q     <= LDW_SKIP; // RQ23
							end
						end else if (state_q == LDW_REG) begin
							ptr_q       <= shift_q; // RQ9
							after_ack_q <= LDW_DATA;
						end else begin
							wr_q.valid  <= 1'b1; // RQ10
							wr_q.addr   <= ptr_q;
							wr_q.data   <= shift_q;
							ptr_q       <= ptr_q + 8'h01; // RQ12
							after_ack_q <= LDW_DATA;
						end
					end
				end
				LDW_ACK: begin
					// Release on the fall that ends the ninth pulse.
					if (scl_fall) begin
						ack_drive_q <= 1'b0; // RQ7
						state_q     <= after_ack_q;
					end
				end
				LDW_SKIP, LDW_IDLE: begin
					ack_drive_q <= 1'b0;
				end
				default: begin
					state_q     <= LDW_IDLE;
					ack_drive_q <= 1'b0;
				end
				endcase
			end
		end
	end

	// Open-drain drive: only low, only during our acknowledge.
	// A constant drive value keeps the pin from ever being pushed high.
	assign sda_o    = 1'b0;
	assign sda_oe_o = ack_drive_q; // RQ3 RQ7

	// Plain control registers, restored by the soft reset key.
	// Writes to offsets with no register are dropped; the pointer moves on.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pdown_q <= LDW_RST_PDOWN;
			ramp_q  <= LDW_RST_RAMP;
			mode_q  <= LDW_RST_MODE;
			curr_q  <= LDW_RST_CURR;
			onoff_q <= LDW_RST_ONOFF;
		end else if (strobe_hit(wr_q, LDW_OFS_SRESET)) begin
			pdown_q <= LDW_RST_PDOWN; // RQ21
			ramp_q  <= LDW_RST_RAMP;
			mode_q  <= LDW_RST_MODE;
			curr_q  <= LDW_RST_CURR;
			onoff_q <= LDW_RST_ONOFF;
		end else if (wr_q.valid) begin
			case (wr_q.addr)
			LDW_OFS_PDOWN: pdown_q <= wr_q.data; // RQ13
			LDW_OFS_RAMP:  ramp_q  <= wr_q.data; // RQ14
			LDW_OFS_MODE:  mode_q  <= wr_q.data; // RQ15
			LDW_OFS_CURR:  curr_q  <= wr_q.data; // RQ16
			LDW_OFS_ONOFF: onoff_q <= wr_q.data; // RQ22
			default: begin
			end
			endcase
		end
	end

	// Duty value: staged copy and applied copy.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			duty_stage_q <= LDW_RST_DUTY;
			duty_act_q   <= LDW_RST_DUTY;
		end else if (strobe_hit(wr_q, LDW_OFS_SRESET)) begin
			duty_stage_q <= LDW_RST_DUTY; // RQ21
			duty_act_q   <= LDW_RST_DUTY;
		end else if (wr_q.valid && wr_q.addr == LDW_OFS_DUTY) begin
			duty_stage_q <= wr_q.data; // RQ19
		end else if (strobe_hit(wr_q, LDW_OFS_DAPPLY)) begin
			duty_act_q <= duty_stage_q; // RQ19
		end
	end

	// Timing values: three staged copies applied together.
	// Apply takes the staged values as they stand before this cycle.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tstart_stage_q <= LDW_RST_TIME;
			trise_stage_q  <= LDW_RST_TIME;
			tfall_stage_q  <= LDW_RST_TIME;
			time_q         <= '{default: LDW_RST_TIME};
		end else if (strobe_hit(wr_q, LDW_OFS_SRESET)) begin
			tstart_stage_q <= LDW_RST_TIME; // RQ21
			trise_stage_q  <= LDW_RST_TIME;
			tfall_stage_q  <= LDW_RST_TIME;
			time_q         <= '{default: LDW_RST_TIME};
		end else if (strobe_hit(wr_q, LDW_OFS_TAPPLY)) begin
			time_q <= '{start_delay: tstart_stage_q,
			            rise_hold:   trise_stage_q,
			            fall_off:    tfall_stage_q}; // RQ20
		end else if (wr_q.valid) begin
			case (wr_q.addr)
			LDW_OFS_TSTART: tstart_stage_q <= wr_q.data; // RQ20
			LDW_OFS_TRISE:  trise_stage_q  <= wr_q.data; // RQ20
			LDW_OFS_TFALL:  tfall_stage_q  <= wr_q.data; // RQ20
			default: begin
			end
			endcase
		end
	end

	// Applied control word; one-shot mode drops duty bit 0.
	// Registered so the analog side sees one clean change per write.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_o <= '{soft_power_down_bit: 1'b1, channel_enable: 1'b0,
			            ramp_enable_bit: 1'b0, hold_phase_select: 1'b0,
			            one_shot_mode: 1'b0, max_current: LDW_I_42MA,
			            duty_level: 8'h00, output_on: 1'b1};
		end else begin
			ctrl_o.soft_power_down_bit <= pdown_q[LDW_BIT_POWER_DOWN]; // RQ13
			ctrl_o.channel_enable      <= pdown_q[LDW_BIT_CHAN_EN]; // RQ13
			ctrl_o.ramp_enable_bit     <= ramp_q[LDW_BIT_RAMP_EN]; // RQ14
			ctrl_o.hold_phase_select   <= ramp_q[LDW_BIT_HOLD_SEL]; // RQ14
			ctrl_o.one_shot_mode       <= mode_q[LDW_BIT_ONE_SHOT]; // RQ15
			ctrl_o.max_current <=
				imax_map(curr_q[LDW_CURR_HI:LDW_CURR_LO]); // RQ16
			if (mode_q[LDW_BIT_ONE_SHOT]) begin
				ctrl_o.duty_level <= {duty_act_q[7:1], 1'b0}; // RQ18
			end else begin
				ctrl_o.duty_level <= duty_act_q; // RQ17
			end
			ctrl_o.output_on <= onoff_q[LDW_BIT_OUT_ON]; // RQ22
		end
	end

	// Timing outputs come straight from their applied register.
	assign time_o = time_q;

endmodule
`default_nettype wire

// ---- verilog/ldw_pkg.sv ----
// Purpose: Shared constants and types for the LED driver write-only serial
//          register front end.
// Assumes: 100 MHz system clock; serial bus pins are sampled, not clocks.
// Notes:   Register offsets are byte addresses on the serial bus.
package ldw_pkg;

	// Own seven-bit bus address.
	localparam logic [6:0] LDW_DEV_ADDR = 7'h68;

	// Register offsets.
	localparam logic [7:0] LDW_OFS_PDOWN   = 8'h00;
	localparam logic [7:0] LDW_OFS_RAMP    = 8'h01;
	localparam logic [7:0] LDW_OFS_MODE    = 8'h02;
	localparam logic [7:0] LDW_OFS_CURR    = 8'h03;
	localparam logic [7:0] LDW_OFS_DUTY    = 8'h04;
	localparam logic [7:0] LDW_OFS_DAPPLY  = 8'h07;
	localparam logic [7:0] LDW_OFS_TSTART  = 8'h0A;
	localparam logic [7:0] LDW_OFS_TRISE   = 8'h10;
	localparam logic [7:0] LDW_OFS_TFALL   = 8'h16;
	localparam logic [7:0] LDW_OFS_TAPPLY  = 8'h1C;
	localparam logic [7:0] LDW_OFS_ONOFF   = 8'h1D;
	localparam logic [7:0] LDW_OFS_SRESET  = 8'h2F;

	// Value that a strobe register needs to fire.
	localparam logic [7:0] LDW_STROBE_KEY = 8'h00;

	// Reset values.
	localparam logic [7:0] LDW_RST_PDOWN = 8'h01;
	localparam logic [7:0] LDW_RST_RAMP  = 8'h00;
	localparam logic [7:0] LDW_RST_MODE  = 8'h00;
	localparam logic [7:0] LDW_RST_CURR  = 8'h00;
	localparam logic [7:0] LDW_RST_DUTY  = 8'h00;
	localparam logic [7:0] LDW_RST_TIME  = 8'h00;
	localparam logic [7:0] LDW_RST_ONOFF = 8'h01;

	// Field positions.
	localparam int LDW_BIT_POWER_DOWN = 0;
	localparam int LDW_BIT_CHAN_EN    = 5;
	localparam int LDW_BIT_RAMP_EN    = 5;
	localparam int LDW_BIT_HOLD_SEL   = 4;
	localparam int LDW_BIT_ONE_SHOT   = 5;
	localparam int LDW_CURR_HI        = 4;
	localparam int LDW_CURR_LO        = 2;
	localparam int LDW_BIT_OUT_ON     = 0;

	// Maximum current codes after folding of the 1xx group.
	typedef enum logic [2:0] {
		LDW_I_42MA   = 3'h0,
		LDW_I_10MA   = 3'h1,
		LDW_I_5MA    = 3'h2,
		LDW_I_30MA   = 3'h3,
		LDW_I_17MA5  = 3'h4
	} ldw_imax_t;

	// Control outputs applied to the analog and timing parts.
	typedef struct packed {
		logic      soft_power_down_bit;
		logic      channel_enable;
		logic      ramp_enable_bit;
		logic      hold_phase_select;
		logic      one_shot_mode;
		ldw_imax_t max_current;
		logic [7:0] duty_level;
		logic      output_on;
	} ldw_ctrl_t;

	// Active timing settings.
	typedef struct packed {
		logic [7:0] start_delay;
		logic [7:0] rise_hold;
		logic [7:0] fall_off;
	} ldw_time_t;

	// One received register write.
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} ldw_wr_t;

endpackage

// ---- verilog/ldw_pin_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to clock_i.
// Notes:   Output changes only once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module ldw_pin_sync
	import ldw_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clock_i,   // System clock.
	input  wire logic rst_n_i,   // Asynchronous reset, active low.
	input  wire logic pin_i,     // Raw pin level.
	output logic      level_o    // Filtered level.
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Filtered level follows only on agreement.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_o <= RST_VAL;
		end else if (s2_q == s3_q) begin
			level_o <= s3_q;
		end
	end

endmodule
`default_nettype wire

// ---- tb/ldw_properties.sv ----
// Purpose: Port-level checks of the serial slave and its registers.
// Assumes: Sees only the ports of ldw_top.
// Notes:   Bound from tb_top.
`timescale 1ns/1ns
`default_nettype none
module ldw_properties
	import ldw_pkg::*;
(
	input wire logic      clock_i,  // System clock.
	input wire logic      rst_n_i,  // Reset, active low.
	input wire logic      scl_i,    // Serial clock pin.
	input wire logic      sda_i,    // Serial data pin.
	input wire logic      sda_o,    // Data drive value.
	input wire logic      sda_oe_o, // Data pull enable.
	input wire ldw_ctrl_t ctrl_o,   // Applied controls.
	input wire ldw_time_t time_o    // Applied timing.
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Bus events seen at the raw pins.
	sequence start_s; scl_i && $fell(sda_i); endsequence
	sequence stop_s; scl_i && $rose(sda_i); endsequence
	sequence ack_s; $rose(sda_oe_o); endsequence
	drive_low_a: assert property (sda_o == 1'b0)
		else $error("data drive value not low");
	ack_rise_a: assert property (ack_s |-> !scl_i)
		else $error("acknowledge raised with clock high");
	ack_fall_a: assert property ($fell(sda_oe_o) |-> !scl_i)
		else $error("acknowledge dropped with clock high");
	ack_whole_a: assert property ($rose(scl_i) && sda_oe_o |->
		sda_oe_o [*8])
		else $error("acknowledge cut short");
	ack_ends_a: assert property (ack_s |-> ##[2:200] $fell(sda_oe_o))
		else $error("acknowledge never released");
	start_quiet_a: assert property (start_s |-> !sda_oe_o [*8])
		else $error("acknowledge right after start");
	stop_idle_a: assert property (stop_s |-> !sda_oe_o [*8])
		else $error("acknowledge after stop");
	ctrl_in_ack_a: assert property ($changed(ctrl_o) |-> sda_oe_o)
		else $error("controls changed outside acknowledge");
	time_in_ack_a: assert property ($changed(time_o) |-> sda_oe_o)
		else $error("timing changed outside acknowledge");
	curr_code_a: assert property (ctrl_o.max_current <= LDW_I_17MA5)
		else $error("current code out of range");
	one_shot_a: assert property (ctrl_o.one_shot_mode &&
		$stable(ctrl_o) |-> !ctrl_o.duty_level[0])
		else $error("duty bit zero used in one-shot");
endmodule
`default_nettype wire

// ---- tb/ldw_master.sv ----
// Purpose: Behavioural bus master that writes the device registers.
// Assumes: Data line has a pull-up; clock is always driven.
// Notes:   Changes its lines on falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module ldw_master
	import ldw_pkg::*;
#(
	parameter int HALF = 12
) (
	input  wire logic clock_i,  // Pacing clock.
	input  wire logic sda_i,    // Resolved data line.
	output var logic  scl_o,    // Serial clock.
	output var logic  sda_oe_o  // High while pulling data low.
);
	// Idle bus: clock high, data left to the pull-up.
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic half();
		repeat (HALF) @(negedge clock_i);
	endtask
	// Clock low, then a gap so data never moves with the edge.
	task automatic low();
		scl_o = 1'b0;
		repeat (4) @(negedge clock_i);
	endtask
	// Start, or repeated start when the clock is low.
	task automatic start();
		sda_oe_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		sda_oe_o = 1'b1;
		half();
		low();
	endtask
	// Sends the top n bits, most significant first.
	task automatic bits(input logic [7:0] v, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sda_oe_o = !v[i];
			half();
			scl_o = 1'b1;
			half();
			low();
		end
	endtask
	// Byte plus ninth pulse; the slave's answer is read high.
	task automatic byte_tx(input logic [7:0] v, output logic ack);
		bits(v, 8);
		sda_oe_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		ack = (sda_i === 1'b0);
		low();
	endtask
	task automatic stop();
		sda_oe_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		sda_oe_o = 1'b0;
		half();
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the serial register front end.
// Assumes: Master model paces the bus; shadows give expectations.
// Notes:   Random data from a fixed seed.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import ldw_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        scl;
	logic        m_oe;
	logic        d_oe;
	logic        d_out;
	logic        sda;
	ldw_ctrl_t   ctrl;
	ldw_time_t   tim;
	int          err_count = 0;
	int          checks_done = 0;
	integer      seed = 20;
	logic [7:0]  pd, rp, md, cu, da, oo, ds, a;
	logic [23:0] ts, ta;
	logic [7:0]  q[$];
	logic        ak;
	// Open-drain data line with pull-up.
	assign sda = !m_oe && (d_oe ? d_out : 1'b1);
	always #5 clk = !clk;
	ldw_top ldw_top_inst (.clock_i(clk), .rst_n_i(rst_n), .scl_i(scl),
		.sda_i(sda), .sda_o(d_out), .sda_oe_o(d_oe), .ctrl_o(ctrl),
		.time_o(tim));
	ldw_master ldw_master_inst (.clock_i(clk), .sda_i(sda), .scl_o(scl),
		.sda_oe_o(m_oe));
	task automatic chk(input logic [31:0] seen, exp, input string nm);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Controls expected from the shadow registers.
	function automatic ldw_ctrl_t exp_c();
		ldw_ctrl_t c;
		c.soft_power_down_bit = pd[0];
		c.channel_enable = pd[5];
		c.ramp_enable_bit = rp[5];
		c.hold_phase_select = rp[4];
		c.one_shot_mode = md[5];
		c.max_current = cu[4] ? LDW_I_17MA5 : ldw_imax_t'({1'b0, cu[3:2]});
		c.duty_level = md[5] ? {da[7:1], 1'b0} : da;
		c.output_on = oo[0];
		return c;
	endfunction
	task automatic defaults();
		{pd, rp, md, cu, da, oo, ts, ta} = {8'h01, 32'h0, 8'h01, 48'h0};
	endtask
	task automatic verify();
		chk(ctrl, exp_c(), "ctrl");
		chk(tim, ta, "time");
	endtask
	// One transfer of the queued bytes; stops at the first refusal.
	task automatic send(input logic want);
		ak = 1'b1;
		ldw_master_inst.start();
		for (int i = 0; i < q.size() && ak; i++) begin
			ldw_master_inst.byte_tx(q[i], ak);
			chk(ak, want, "ack");
		end
		ldw_master_inst.stop();
	endtask
	task automatic wr(input logic [7:0] r, d);
		q = '{{LDW_DEV_ADDR, 1'b0}, r, d};
		send(1'b1);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog against a hung bus; about twice the expected run.
	initial begin
		#600000;
		err_count++;
		summarize();
	end
	// Main sequence.
	initial begin
		defaults();
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		verify();
		for (int k = 0; k < 8; k++) begin
			{pd, rp, md, cu, ds} = 40'({$random(seed), $random(seed)});
			cu[4:2] = 3'(k);
			md[5] = k[1];
			q = '{{LDW_DEV_ADDR, 1'b0}, 8'h00, pd, rp, md, cu, ds};
			send(1'b1);
			verify();
			wr(LDW_OFS_DAPPLY, k[0] ? 8'h00 : 8'h3C);
			if (k[0])
				da = ds;
			verify();
		end
		for (int j = 0; j < 2; j++) begin
			a = $random(seed);
			if (a[7:1] == LDW_DEV_ADDR)
				a[7] = !a[7];
			a[0] = 1'b0;
			q = '{j ? {LDW_DEV_ADDR, 1'b1} : a, 8'h00, 8'h00};
			send(1'b0);
			verify();
		end
		ts = 24'($random(seed));
		wr(LDW_OFS_TSTART, ts[23:16]);
		wr(LDW_OFS_TRISE, ts[15:8]);
		wr(LDW_OFS_TFALL, ts[7:0]);
		verify();
		wr(LDW_OFS_TAPPLY, 8'h01);
		verify();
		wr(LDW_OFS_TAPPLY, 8'h00);
		ta = ts;
		verify();
		wr(LDW_OFS_ONOFF, 8'h00);
		oo = 8'h00;
		verify();
		// A byte cut by a repeated start is dropped.
		ldw_master_inst.start();
		ldw_master_inst.byte_tx({LDW_DEV_ADDR, 1'b0}, ak);
		chk(ak, 1'b1, "ack");
		ldw_master_inst.byte_tx(LDW_OFS_ONOFF, ak);
		chk(ak, 1'b1, "ack");
		ldw_master_inst.bits(8'hFF, 5);
		verify();
		q = '{{LDW_DEV_ADDR, 1'b0}, LDW_OFS_ONOFF, 8'h01};
		send(1'b1);
		oo = 8'h01;
		verify();
		wr(LDW_OFS_SRESET, 8'h5A);
		verify();
		wr(LDW_OFS_SRESET, 8'h00);
		defaults();
		verify();
		// Power-up defaults again after a reset in mid-run.
		wr(LDW_OFS_MODE, 8'h20);
		md = 8'h20;
		verify();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		defaults();
		repeat (10) @(negedge clk);
		verify();
		summarize();
	end
endmodule
bind ldw_top ldw_properties ldw_properties_inst (.clock_i(clock_i),
	.rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .ctrl_o(ctrl_o), .time_o(time_o));
`default_nettype wire
